// ==== src/lcp_device.sv ====
// module: bus comparator, capture registers, power-fail control and indicators
// Summary of operation
// - both processors run buses in cycle lockstep
// - compare both buses on every cycle outside asynchronous mode
// - any mismatch raises interrupt to both
// - processors stop execution on the interrupt
// - locate fault in partner, healthy keeps mastership
// - inconclusive localisation leads to full self-test
// - fault dead time one to fifty ms
// - mismatch forces asynchronous mode, stops comparison
// - latch address and control at mismatch
// - stay independent until new synchronization run
// - power-fail warning: finish instruction, then idle
// - memory-protect disables all memory access
// - reverse warning/protect ordering at power-up
// - central reset holds defined state, starts there
// - supply spaces warning and protect 700 us
// - run initialization routine after power-on
// - defined stop before power failure hits
// - memory indicators driven only while loading
// - encode load status onto red/green indicators
// - stop lamp on memory or hardware fault
`timescale 1ns/1ps
`default_nettype none
module lcp_device (
    input wire logic i_clk,
    input wire logic i_rst,
    lcp_if.device bus,
    input wire logic i_instr_done,
    input wire logic i_init_done,
    input wire logic i_sync_run,
    input wire logic i_capture_read,
    input wire logic i_loading,
    input wire lcp_pkg::lcp_load_e i_load_status,
    input wire logic i_mem_fault,
    input wire logic i_cpu_fault,
    output logic o_mismatch_interrupt,
    output logic o_async_mode,
    output logic o_capture_valid,
    output logic [lcp_pkg::ADDR_W-1:0] o_capture_addr,
    output logic [lcp_pkg::CTRL_W-1:0] o_capture_ctrl,
    output logic o_fetch_enable,
    output logic o_mem_enable,
    output logic o_init_active,
    output logic o_halted,
    output logic o_led_red,
    output logic o_led_green,
    output logic o_stop_lamp
);
    // ========================================
    // comparison
    lcp_pkg::lcp_state_e state_q;
    logic diff;
    logic mismatch;
    logic [lcp_pkg::CNT_W-1:0] blink_cnt_q;
    logic blink_q;

    always_comb begin
        diff = (bus.bus_valid_a != bus.bus_valid_b) || (bus.addr_a != bus.addr_b)
            || (bus.data_a != bus.data_b) || (bus.ctrl_a != bus.ctrl_b);
        mismatch = !o_async_mode && (diff || bus.io_mismatch);
    end

    // asynchronous mode until a synchronization run
    always_ff @(posedge i_clk) begin
        if (i_rst || bus.central_reset) begin
            o_async_mode <= 1'b0;
        end else if (mismatch) begin
            o_async_mode <= 1'b1;
        end else if (i_sync_run) begin
            o_async_mode <= 1'b0;
        end
    end

    // interrupt pulse to both processors
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_mismatch_interrupt <= 1'b0;
        end else begin
            o_mismatch_interrupt <= mismatch;
        end
    end

    // ========================================
    // capture registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_capture_valid <= 1'b0;
            o_capture_addr <= '0;
            o_capture_ctrl <= '0;
        end else if (mismatch && !o_capture_valid) begin
            o_capture_valid <= 1'b1;
            o_capture_addr <= bus.addr_a;
            o_capture_ctrl <= bus.ctrl_a;
        end else if (i_capture_read || i_sync_run) begin
            o_capture_valid <= 1'b0;
        end
    end

    // ========================================
    // run control
    always_ff @(posedge i_clk) begin
        if (i_rst || bus.central_reset) begin
            state_q <= lcp_pkg::LCP_ST_RESET;
        end else begin
            unique case (state_q)
                lcp_pkg::LCP_ST_RESET: begin
                    if (!bus.power_fail_warning && !bus.memory_protect) begin
                        state_q <= lcp_pkg::LCP_ST_INIT;
                    end
                end
                lcp_pkg::LCP_ST_INIT: begin
                    if (bus.power_fail_warning) begin
                        state_q <= lcp_pkg::LCP_ST_HALT;
                    end else if (i_init_done) begin
                        state_q <= lcp_pkg::LCP_ST_RUN;
                    end
                end
                lcp_pkg::LCP_ST_RUN: begin
                    if (i_mem_fault || i_cpu_fault) begin
                        state_q <= lcp_pkg::LCP_ST_STOP;
                    end else if (bus.power_fail_warning && i_instr_done) begin
                        state_q <= lcp_pkg::LCP_ST_HALT;
                    end
                end
                lcp_pkg::LCP_ST_HALT: begin
                    if (!bus.power_fail_warning && !bus.memory_protect) begin
                        state_q <= lcp_pkg::LCP_ST_INIT;
                    end
                end
                lcp_pkg::LCP_ST_STOP: begin
                    state_q <= lcp_pkg::LCP_ST_STOP;
                end
                default: begin
                    state_q <= lcp_pkg::LCP_ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_fetch_enable <= 1'b0;
            o_mem_enable <= 1'b0;
            o_init_active <= 1'b0;
            o_halted <= 1'b1;
            o_stop_lamp <= 1'b0;
        end else begin
            o_fetch_enable <= (state_q == lcp_pkg::LCP_ST_RUN || state_q == lcp_pkg::LCP_ST_INIT)
                && !bus.power_fail_warning;
            o_mem_enable <= !bus.memory_protect && state_q != lcp_pkg::LCP_ST_RESET;
            o_init_active <= state_q == lcp_pkg::LCP_ST_INIT;
            o_halted <= state_q != lcp_pkg::LCP_ST_RUN && state_q != lcp_pkg::LCP_ST_INIT;
            o_stop_lamp <= state_q == lcp_pkg::LCP_ST_STOP;
        end
    end

    // ========================================
    // memory module indicators
    always_ff @(posedge i_clk) begin
        if (i_rst || blink_cnt_q == lcp_pkg::CNT_W'(lcp_pkg::BLINK_CYC - 1)) begin
            blink_cnt_q <= '0;
        end else begin
            blink_cnt_q <= blink_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            blink_q <= 1'b0;
        end else if (blink_cnt_q == lcp_pkg::CNT_W'(lcp_pkg::BLINK_CYC - 1)) begin
            blink_q <= !blink_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || !i_loading) begin
            o_led_red <= 1'b0;
            o_led_green <= 1'b0;
        end else begin
            unique case (i_load_status)
                lcp_pkg::LCP_LD_BUSY: begin
                    o_led_red <= 1'b0;
                    o_led_green <= 1'b1;
                end
                lcp_pkg::LCP_LD_OK: begin
                    o_led_red <= 1'b0;
                    o_led_green <= 1'b0;
                end
                lcp_pkg::LCP_LD_NODISK: begin
                    o_led_red <= blink_q;
                    o_led_green <= 1'b0;
                end
                lcp_pkg::LCP_LD_FAULT: begin
                    o_led_red <= 1'b1;
                    o_led_green <= 1'b0;
                end
                lcp_pkg::LCP_LD_DEFECT: begin
                    o_led_red <= 1'b1;
                    o_led_green <= 1'b1;
                end
                default: begin
                    o_led_red <= 1'b1;
                    o_led_green <= 1'b1;
                end
            endcase
        end
    end

    assign bus.mismatch_interrupt = o_mismatch_interrupt;
    assign bus.async_mode = o_async_mode;
    assign bus.halted = o_halted;
    assign bus.mem_enable = o_mem_enable;
endmodule // lcp_device
`default_nettype wire

// ==== src/lcp_if.sv ====
// interface: lockstep buses, power-fail signals and compare results between the ends
`timescale 1ns/1ps
`default_nettype none
interface lcp_if;
    logic bus_valid_a;
    logic [lcp_pkg::ADDR_W-1:0] addr_a;
    logic [lcp_pkg::DATA_W-1:0] data_a;
    logic [lcp_pkg::CTRL_W-1:0] ctrl_a;
    logic bus_valid_b;
    logic [lcp_pkg::ADDR_W-1:0] addr_b;
    logic [lcp_pkg::DATA_W-1:0] data_b;
    logic [lcp_pkg::CTRL_W-1:0] ctrl_b;
    logic io_mismatch;
    logic power_fail_warning;
    logic memory_protect;
    logic central_reset;
    logic mismatch_interrupt;
    logic async_mode;
    logic halted;
    logic mem_enable;
    modport device (
        input bus_valid_a, addr_a, data_a, ctrl_a,
        input bus_valid_b, addr_b, data_b, ctrl_b,
        input io_mismatch, power_fail_warning, memory_protect, central_reset,
        output mismatch_interrupt, async_mode, halted, mem_enable
    );
    modport other (
        output bus_valid_a, addr_a, data_a, ctrl_a,
        output bus_valid_b, addr_b, data_b, ctrl_b,
        output io_mismatch, power_fail_warning, memory_protect, central_reset,
        input mismatch_interrupt, async_mode, halted, mem_enable
    );
endinterface
`default_nettype wire

// ==== src/lcp_other.sv ====
// module: lockstep processor pair and power supply sequencing
`timescale 1ns/1ps
`default_nettype none
module lcp_other #(
    parameter int unsigned PFW_TO_MP_CYC = lcp_pkg::PFW_TO_MP_CYC,
    parameter int unsigned DEAD_MIN_CYC = lcp_pkg::DEAD_MIN_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    lcp_if.other bus,
    input wire logic i_bus_valid,
    input wire logic [lcp_pkg::ADDR_W-1:0] i_addr,
    input wire logic [lcp_pkg::DATA_W-1:0] i_data,
    input wire logic [lcp_pkg::CTRL_W-1:0] i_ctrl,
    input wire logic [lcp_pkg::DATA_W-1:0] i_data_b_err,
    input wire logic i_io_mismatch,
    input wire logic i_supply_ok,
    input wire logic i_central_reset,
    input wire logic i_diag_done,
    output logic o_exec_stopped,
    output logic o_dead_min_met,
    output logic o_supply_ready
);
    // ========================================
    // lockstep buses driven from one source
    logic [lcp_pkg::CNT_W-1:0] pf_cnt_q;
    logic [lcp_pkg::CNT_W-1:0] dead_cnt_q;
    logic pfw_q;
    logic mp_q;
    logic bv_q;
    logic [lcp_pkg::ADDR_W-1:0] addr_q;
    logic [lcp_pkg::DATA_W-1:0] data_a_q;
    logic [lcp_pkg::DATA_W-1:0] data_b_q;
    logic [lcp_pkg::CTRL_W-1:0] ctrl_q;
    logic iom_q;
    logic zrs_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bv_q <= 1'b0;
            addr_q <= '0;
            data_a_q <= '0;
            data_b_q <= '0;
            ctrl_q <= '0;
            iom_q <= 1'b0;
            zrs_q <= 1'b1;
        end else begin
            bv_q <= i_bus_valid && !o_exec_stopped;
            addr_q <= i_addr;
            data_a_q <= i_data;
            data_b_q <= i_data ^ i_data_b_err;
            ctrl_q <= i_ctrl;
            iom_q <= i_io_mismatch;
            zrs_q <= i_central_reset;
        end
    end

    // ========================================
    // halt on interrupt, hold for least dead time
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_exec_stopped <= 1'b0;
            dead_cnt_q <= '0;
            o_dead_min_met <= 1'b0;
        end else if (bus.mismatch_interrupt) begin
            o_exec_stopped <= 1'b1;
            dead_cnt_q <= '0;
            o_dead_min_met <= 1'b0;
        end else if (o_exec_stopped) begin
            if (dead_cnt_q != lcp_pkg::CNT_W'(DEAD_MIN_CYC - 1)) begin
                dead_cnt_q <= dead_cnt_q + 1'b1;
            end else begin
                o_dead_min_met <= 1'b1;
            end
            if (o_dead_min_met && i_diag_done) begin
                o_exec_stopped <= 1'b0;
            end
        end
    end

    // ========================================
    // supply: warning first, protect after spacing
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pfw_q <= 1'b1;
            mp_q <= 1'b1;
            pf_cnt_q <= '0;
            o_supply_ready <= 1'b0;
        end else if (!i_supply_ok) begin
            pfw_q <= 1'b1;
            o_supply_ready <= 1'b0;
            if (pf_cnt_q != lcp_pkg::CNT_W'(PFW_TO_MP_CYC)) begin
                pf_cnt_q <= pf_cnt_q + 1'b1;
            end else begin
                mp_q <= 1'b1;
            end
        end else begin
            pf_cnt_q <= '0;
            mp_q <= 1'b0;
            pfw_q <= mp_q;
            o_supply_ready <= !pfw_q;
        end
    end

    assign bus.bus_valid_a = bv_q;
    assign bus.bus_valid_b = bv_q;
    assign bus.addr_a = addr_q;
    assign bus.addr_b = addr_q;
    assign bus.data_a = data_a_q;
    assign bus.data_b = data_b_q;
    assign bus.ctrl_a = ctrl_q;
    assign bus.ctrl_b = ctrl_q;
    assign bus.io_mismatch = iom_q;
    assign bus.power_fail_warning = pfw_q;
    assign bus.memory_protect = mp_q;
    assign bus.central_reset = zrs_q;
endmodule // lcp_other
`default_nettype wire

// ==== src/lcp_pkg.sv ====
// package: shared constants and types for the lockstep compare and power-fail control
`default_nettype none
package lcp_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CTRL_W = 4;
    localparam int unsigned CLK_MHZ = 250;
    // fault dead time window in milliseconds
    localparam int unsigned DEAD_MIN_MS = 1;
    localparam int unsigned DEAD_MAX_MS = 50;
    localparam int unsigned DEAD_TYP_MS = 5;
    localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
    localparam int unsigned DEAD_MIN_CYC = DEAD_MIN_MS * CYC_PER_MS;
    localparam int unsigned DEAD_MAX_CYC = DEAD_MAX_MS * CYC_PER_MS;
    // power-fail warning to memory-protect spacing
    localparam int unsigned PFW_TO_MP_US = 700;
    localparam int unsigned PFW_TO_MP_CYC = PFW_TO_MP_US * CLK_MHZ;
    // indicator blink half period
    localparam int unsigned BLINK_MS = 250;
    localparam int unsigned BLINK_CYC = BLINK_MS * CYC_PER_MS;
    // wide enough for the blink half period count
    localparam int unsigned CNT_W = 26;
    // load status codes from the memory module
    typedef enum logic [2:0] {
        LCP_LD_BUSY = 3'h0,
        LCP_LD_OK = 3'h1,
        LCP_LD_NODISK = 3'h2,
        LCP_LD_FAULT = 3'h3,
        LCP_LD_DEFECT = 3'h4
    } lcp_load_e;
    // processor run states, one-hot
    typedef enum logic [4:0] {
        LCP_ST_RESET = 5'h01,
        LCP_ST_INIT = 5'h02,
        LCP_ST_RUN = 5'h04,
        LCP_ST_HALT = 5'h08,
        LCP_ST_STOP = 5'h10
    } lcp_state_e;
endpackage
`default_nettype wire

// ==== verification/lcp_checker.sv ====
// checker: timing relations on the interface between the two ends
`timescale 1ns/1ps
`default_nettype none
module lcp_checker #(
    parameter int unsigned PFW_TO_MP_CYC = lcp_pkg::PFW_TO_MP_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic bus_valid_a,
    input wire logic bus_valid_b,
    input wire logic [lcp_pkg::DATA_W-1:0] data_a,
    input wire logic [lcp_pkg::DATA_W-1:0] data_b,
    input wire logic io_mismatch,
    input wire logic power_fail_warning,
    input wire logic memory_protect,
    input wire logic central_reset,
    input wire logic mismatch_interrupt,
    input wire logic async_mode,
    input wire logic halted,
    input wire logic mem_enable
);
    // ==========================================
    // warning duration counter
    logic [lcp_pkg::CNT_W-1:0] pfw_cnt_q;
    always_ff @(posedge i_clk) begin
        if (i_rst || !power_fail_warning) begin
            pfw_cnt_q <= '0;
        end else if (pfw_cnt_q != '1) begin
            pfw_cnt_q <= pfw_cnt_q + 1'b1;
        end
    end
    // ==========================================
    // assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_cmp_diff;
        !async_mode && !central_reset
            && (io_mismatch || (bus_valid_a && bus_valid_b && data_a != data_b));
    endsequence
    sequence s_irq_enter;
        mismatch_interrupt ##0 async_mode;
    endsequence
    mism_irq_a: assert property (s_cmp_diff |=> s_irq_enter)
        else $error("mismatch without interrupt and async entry");
    irq_pulse_a: assert property (mismatch_interrupt |=> !mismatch_interrupt)
        else $error("interrupt longer than one cycle");
    async_quiet_a: assert property (async_mode |=> !mismatch_interrupt)
        else $error("interrupt while asynchronous");
    mem_lock_a: assert property (memory_protect |=> !mem_enable)
        else $error("memory enabled under protect");
    pfw_space_a: assert property ($rose(memory_protect) |-> 32'(pfw_cnt_q) >= PFW_TO_MP_CYC)
        else $error("protect too soon after warning");
    up_order_a: assert property ($fell(power_fail_warning) |-> !memory_protect)
        else $error("warning released before protect");
    stop_first_a: assert property ($rose(memory_protect) |-> halted)
        else $error("protect before processor halted");
    creset_hold_a: assert property (central_reset ##1 central_reset |=> halted && !async_mode)
        else $error("central reset not holding basic state");
endmodule // lcp_checker
`default_nettype wire

// ==== verification/testbench.sv ====
// testbench: both ends joined, driven from their user sides
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int unsigned PFW_CYC = 20;
    localparam int unsigned DEAD_CYC = 10;
    logic i_clk = 1'b0, i_rst = 1'b1;
    logic instr_done = 1'b1, init_done = 1'b0, sync_run = 1'b0, cap_read = 1'b0, loading = 1'b0;
    lcp_pkg::lcp_load_e load_status = lcp_pkg::LCP_LD_BUSY;
    logic mem_fault = 1'b0, cpu_fault = 1'b0, bus_valid = 1'b0, io_mis = 1'b0;
    logic supply_ok = 1'b1, creset = 1'b0, diag_done = 1'b0;
    logic [lcp_pkg::ADDR_W-1:0] addr = 16'h0000;
    logic [lcp_pkg::DATA_W-1:0] data = 16'h0000, err = 16'h0000;
    logic [lcp_pkg::CTRL_W-1:0] ctrl = 4'h0;
    logic irq, async_m, cap_valid, fetch, mem_en, init_act, halted, red, green, stop;
    logic exec_stopped, dead_met, sup_rdy;
    logic [lcp_pkg::ADDR_W-1:0] cap_addr;
    logic [lcp_pkg::CTRL_W-1:0] cap_ctrl;
    int errors = 0, num_checks = 0;
    logic [31:0] seed = 32'h0000EC5A;
    logic [20:0] exp_q [$];
    lcp_if lif();
    lcp_device lcp_device_i (.i_clk(i_clk), .i_rst(i_rst), .bus(lif), .i_instr_done(instr_done),
        .i_init_done(init_done), .i_sync_run(sync_run), .i_capture_read(cap_read),
        .i_loading(loading), .i_load_status(load_status), .i_mem_fault(mem_fault),
        .i_cpu_fault(cpu_fault), .o_mismatch_interrupt(irq), .o_async_mode(async_m),
        .o_capture_valid(cap_valid), .o_capture_addr(cap_addr), .o_capture_ctrl(cap_ctrl),
        .o_fetch_enable(fetch), .o_mem_enable(mem_en), .o_init_active(init_act),
        .o_halted(halted), .o_led_red(red), .o_led_green(green), .o_stop_lamp(stop));
    lcp_other #(.PFW_TO_MP_CYC(PFW_CYC), .DEAD_MIN_CYC(DEAD_CYC)) lcp_other_i (.i_clk(i_clk),
        .i_rst(i_rst), .bus(lif), .i_bus_valid(bus_valid), .i_addr(addr), .i_data(data),
        .i_ctrl(ctrl), .i_data_b_err(err), .i_io_mismatch(io_mis), .i_supply_ok(supply_ok),
        .i_central_reset(creset), .i_diag_done(diag_done), .o_exec_stopped(exec_stopped),
        .o_dead_min_met(dead_met), .o_supply_ready(sup_rdy));
    lcp_checker #(.PFW_TO_MP_CYC(PFW_CYC)) lcp_checker_i (.i_clk(i_clk), .i_rst(i_rst),
        .bus_valid_a(lif.bus_valid_a), .bus_valid_b(lif.bus_valid_b), .data_a(lif.data_a),
        .data_b(lif.data_b), .io_mismatch(lif.io_mismatch),
        .power_fail_warning(lif.power_fail_warning), .memory_protect(lif.memory_protect),
        .central_reset(lif.central_reset), .mismatch_interrupt(lif.mismatch_interrupt),
        .async_mode(lif.async_mode), .halted(lif.halted), .mem_enable(lif.mem_enable));
    // ==========================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
            errors++;
        end
    endtask
    task automatic complete_run();
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic bring_up();
        for (int k = 0; k < 300 && init_act !== 1'b1; k++) @(negedge i_clk);
        chk("init_active", 1, init_act);
        chk("supply_ready", 1, sup_rdy);
        @(posedge i_clk) init_done <= 1'b1;
        @(posedge i_clk) init_done <= 1'b0;
        for (int k = 0; k < 20 && fetch !== 1'b1; k++) @(negedge i_clk);
        chk("fetch_enable", 1, fetch);
        chk("mem_enable", 1, mem_en);
    endtask
    // ==========================================
    // clock, watchdog, capture monitor
    initial begin
        forever #2 i_clk = ~i_clk;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        complete_run();
    end
    always @(negedge i_clk) begin
        if (irq === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected_irq", 0, 1);
            end else begin
                chk("capture", exp_q.pop_front(), {cap_valid, cap_ctrl, cap_addr});
            end
        end
    end
    // ==========================================
    // main sequence
    initial begin
        lcp_pkg::lcp_load_e st [4];
        logic [1:0] led [4];
        logic [20:0] cap_exp;
        st = '{lcp_pkg::LCP_LD_BUSY, lcp_pkg::LCP_LD_OK, lcp_pkg::LCP_LD_FAULT,
            lcp_pkg::LCP_LD_DEFECT};
        led = '{2'b01, 2'b00, 2'b10, 2'b11};
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        bring_up();
        for (int i = 0; i < 5; i++) begin
            @(posedge i_clk) loading <= (i < 4);
            load_status <= st[i % 4];
            repeat (3) @(negedge i_clk);
            chk("leds", (i < 4) ? led[i] : 2'b00, {red, green});
        end
        @(posedge i_clk) loading <= 1'b1;
        load_status <= lcp_pkg::LCP_LD_NODISK;
        repeat (3) @(negedge i_clk);
        chk("green_nodisk", 0, green);
        chk("red_nodisk", 0, red);
        @(posedge i_clk) loading <= 1'b0;
        for (int c = 0; c < 2; c++) begin
            repeat (20) begin
                @(posedge i_clk) seed = lfsr(seed);
                bus_valid <= 1'b1;
                addr <= seed[15:0];
                data <= seed[31:16];
                ctrl <= seed[3:0];
            end
            @(posedge i_clk) seed = lfsr(seed);
            addr <= seed[15:0];
            ctrl <= seed[7:4];
            err <= (c == 0) ? (seed[31:16] | 16'h0001) : 16'h0000;
            io_mis <= (c == 1);
            cap_exp = {1'b1, seed[7:4], seed[15:0]};
            exp_q.push_back(cap_exp);
            repeat (5) @(negedge i_clk);
            chk("exec_stopped", 1, exec_stopped);
            chk("dead_early", 0, dead_met);
            @(posedge i_clk) err <= 16'h00F0;
            io_mis <= 1'b0;
            repeat (DEAD_CYC + 6) @(negedge i_clk);
            chk("dead_met", 1, dead_met);
            chk("async_mode", 1, async_m);
            chk("capture_held", cap_exp, {cap_valid, cap_ctrl, cap_addr});
            @(posedge i_clk) err <= 16'h0000;
            cap_read <= 1'b1;
            diag_done <= 1'b1;
            @(posedge i_clk) cap_read <= 1'b0;
            diag_done <= 1'b0;
            repeat (4) @(negedge i_clk);
            chk("capture_read", 0, cap_valid);
            chk("exec_resumed", 0, exec_stopped);
            chk("async_kept", 1, async_m);
            @(posedge i_clk) sync_run <= 1'b1;
            @(posedge i_clk) sync_run <= 1'b0;
            repeat (3) @(negedge i_clk);
            chk("async_cleared", 0, async_m);
        end
        chk("queue_empty", 0, exp_q.size());
        @(posedge i_clk) supply_ok <= 1'b0;
        instr_done <= 1'b0;
        repeat (6) @(negedge i_clk);
        chk("halted_busy", 0, halted);
        chk("fetch_pfw", 0, fetch);
        chk("supply_ready_pfw", 0, sup_rdy);
        @(posedge i_clk) instr_done <= 1'b1;
        repeat (3) @(negedge i_clk);
        chk("halted_pfw", 1, halted);
        repeat (PFW_CYC + 4) @(negedge i_clk);
        chk("mem_protect", 0, mem_en);
        @(posedge i_clk) supply_ok <= 1'b1;
        bring_up();
        for (int f = 0; f < 2; f++) begin
            @(posedge i_clk) mem_fault <= (f == 0);
            cpu_fault <= (f == 1);
            @(posedge i_clk) mem_fault <= 1'b0;
            cpu_fault <= 1'b0;
            repeat (4) @(negedge i_clk);
            chk("stop_lamp", 1, stop);
            chk("halted_stop", 1, halted);
            @(posedge i_clk) creset <= 1'b1;
            repeat (5) @(negedge i_clk);
            chk("halted_creset", 1, halted);
            chk("stop_creset", 0, stop);
            @(posedge i_clk) creset <= 1'b0;
            bring_up();
        end
        complete_run();
    end
endmodule // testbench
`default_nettype wire
